// file: hw/sff_pkg.sv
// Purpose: shared constants and types of the serial flash front end
// Assumes: 50 MHz system clock
// Notes: link pins travel as one struct
package sff_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int OPCODE_BITS = 8;
    localparam int ADDR_BYTES = 3;
    localparam int ADDR_BITS = ADDR_BYTES * 8;
    localparam int PAGE_COUNT = 2048;
    localparam int PAGE_ADDR_BITS = 11;
    localparam int PAGE_BYTES_STD = 264;
    localparam int PAGE_BYTES_BIN = 256;
    localparam int BYTE_ADDR_BITS = 9;
    localparam int NUM_BUFFERS = 2;
    localparam int FIFO_DEPTH_DEF = 4;
    // self-timed program/erase cycle length
    localparam int CYCLE_TIME_NS = 100000;
    localparam int CYCLE_CLKS_DEF = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SFF_IDLE = 2'b00,
        SFF_OPCODE = 2'b01,
        SFF_ADDR = 2'b10,
        SFF_DATA = 2'b11
    } sff_state_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } sff_link_t;

    typedef struct packed {
        logic [OPCODE_BITS-1:0] opcode;
        logic [ADDR_BITS-1:0] addr;
    } sff_cmd_t;
endpackage : sff_pkg

// file: hw/sff_fifo.sv
// Purpose: small valid/ready FIFO
// Assumes: depth a power of two, at least 2
// Notes: output word is read straight from the array
`timescale 1ns/1ps
module sff_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_no_overfill;
        count == (AW+1)'(DEPTH) |-> !in_ready_out ##0 (push == 1'b0);
    endproperty
    a_no_overfill: assert property (p_no_overfill) else $error("fifo accepted while full");

    property p_count_track;
        push && !pop |=> count == $past(count) + 1'b1;
    endproperty
    a_count_track: assert property (p_count_track) else $error("fifo count missed a push");

    c_fifo_full: cover property (count == (AW+1)'(DEPTH));
endmodule : sff_fifo

// file: hw/sff_front_end.sv
// Purpose: serial interface front end of a paged serial flash
// Assumes: link pins sampled by clk_in, link clock much slower than clk_in
// Notes: opcode meaning is decoded outside and reported back on read_op_in/timed_op_in
`timescale 1ns/1ps
module sff_front_end #(
    parameter int CYCLE_CLKS = sff_pkg::CYCLE_CLKS_DEF,
    parameter int FIFO_DEPTH = sff_pkg::FIFO_DEPTH_DEF
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire sff_pkg::sff_link_t link_in,
    input wire logic reset_pin_n_in,
    output logic so_out,
    output logic so_oe_out,
    input wire logic page_bin_in,
    input wire logic buf_sel_in,
    input wire logic read_op_in,
    input wire logic timed_op_in,
    output sff_pkg::sff_cmd_t cmd_out,
    output logic cmd_valid_out,
    output logic [sff_pkg::PAGE_ADDR_BITS-1:0] page_addr_out,
    output logic [7:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    input wire logic [sff_pkg::BYTE_ADDR_BITS-1:0] prog_addr_in,
    output logic [7:0] prog_data_out,
    output logic busy_out,
    output logic selected_out,
    output logic standby_out
);
    import sff_pkg::*;
    localparam int CNT_W = $clog2(CYCLE_CLKS + 1);
    if (CYCLE_CLKS < 1) begin : g_chk
        $error("cycle length must be at least one clock");
    end
    function automatic logic [PAGE_ADDR_BITS-1:0] page_of(input logic [ADDR_BITS-1:0] a,
                                                          input logic bin);
        page_of = bin ? a[18:8] : a[19:9];
    endfunction : page_of
    function automatic logic [BYTE_ADDR_BITS-1:0] byte_of(input logic [ADDR_BITS-1:0] a,
                                                          input logic bin);
        byte_of = bin ? {1'b0, a[7:0]} : a[8:0];
    endfunction : byte_of
    sff_link_t link_s1;
    sff_link_t link_s2;
    sff_link_t link_prev;
    logic rpin_s1;
    logic rpin_s2;
    logic abort;
    logic sel;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    sff_state_t state;
    logic [2:0] bit_cnt;
    logic [1:0] addr_cnt;
    logic [7:0] in_sh;
    logic [7:0] next_byte;
    logic [7:0] out_sh;
    logic [BYTE_ADDR_BITS-1:0] wr_ptr;
    logic [BYTE_ADDR_BITS-1:0] page_last;
    logic [CNT_W-1:0] busy_cnt;
    logic prog_buf;
    logic [7:0] mem [0:NUM_BUFFERS-1][0:PAGE_BYTES_STD-1];
    logic tx_valid;
    logic tx_pop;
    logic [7:0] tx_byte;
    logic load_out;

    // two-stage synchronisers for all pins
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            link_s1 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
            link_s2 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
            link_prev <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
            rpin_s1 <= 1'b0;
            rpin_s2 <= 1'b0;
        end else begin
            link_s1 <= link_in;
            link_s2 <= link_s1;
            link_prev <= link_s2;
            rpin_s1 <= reset_pin_n_in;
            rpin_s2 <= rpin_s1;
        end
    end

    assign abort = !rpin_s2;
    assign sel = !link_s2.cs_n && !abort;
    assign cs_fall = link_prev.cs_n && !link_s2.cs_n && !abort;
    assign cs_rise = !link_prev.cs_n && link_s2.cs_n;
    assign sck_rise = sel && !cs_fall && !link_prev.sck && link_s2.sck;
    assign sck_fall = sel && !cs_fall && link_prev.sck && !link_s2.sck;
    assign next_byte = {in_sh[6:0], link_s2.si};
    assign so_oe_out = sel;
    assign selected_out = sel;
    assign standby_out = !sel && !busy_out;
    assign page_last = page_bin_in ? BYTE_ADDR_BITS'(PAGE_BYTES_BIN - 1)
                                   : BYTE_ADDR_BITS'(PAGE_BYTES_STD - 1);

    // framing, opcode and address capture
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= SFF_IDLE;
            bit_cnt <= '0;
            addr_cnt <= '0;
            in_sh <= '0;
            cmd_out <= '0;
            page_addr_out <= '0;
            cmd_valid_out <= 1'b0;
            rx_data_out <= '0;
            rx_valid_out <= 1'b0;
        end else begin
            cmd_valid_out <= 1'b0;
            rx_valid_out <= 1'b0;
            if (!sel) begin
                state <= SFF_IDLE;
            end else if (cs_fall) begin
                state <= SFF_OPCODE;
                bit_cnt <= '0;
                addr_cnt <= '0;
                in_sh <= '0;
            end else if (sck_rise && state != SFF_IDLE) begin
                in_sh <= next_byte;
                bit_cnt <= bit_cnt + 3'd1;
                if (bit_cnt == 3'd7) begin
                    case (state)
                        SFF_OPCODE: begin
                            cmd_out.opcode <= next_byte;
                            state <= SFF_ADDR;
                        end
                        SFF_ADDR: begin
                            cmd_out.addr <= {cmd_out.addr[ADDR_BITS-9:0], next_byte};
                            addr_cnt <= addr_cnt + 2'd1;
                            if (addr_cnt == 2'(ADDR_BYTES - 1)) begin
                                state <= SFF_DATA;
                                cmd_valid_out <= 1'b1;
                                page_addr_out <= page_of({cmd_out.addr[ADDR_BITS-9:0], next_byte},
                                                         page_bin_in);
                            end
                        end
                        SFF_DATA: begin
                            rx_data_out <= next_byte;
                            rx_valid_out <= 1'b1;
                        end
                        default: state <= SFF_IDLE;
                    endcase
                end
            end
        end
    end
    // self-timed program/erase cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
            busy_cnt <= '0;
            prog_buf <= 1'b0;
        end else if (abort) begin
            busy_out <= 1'b0;
            busy_cnt <= '0;
        end else if (cs_rise && state == SFF_DATA && timed_op_in && !busy_out) begin
            busy_out <= 1'b1;
            busy_cnt <= CNT_W'(CYCLE_CLKS - 1);
            prog_buf <= buf_sel_in;
        end else if (busy_out) begin
            if (busy_cnt == '0) begin
                busy_out <= 1'b0;
            end else begin
                busy_cnt <= busy_cnt - 1'b1;
            end
        end
    end
    // page buffers: writes to the buffer being programmed are dropped
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
        end else if (cmd_valid_out) begin
            wr_ptr <= byte_of(cmd_out.addr, page_bin_in);
        end else if (rx_valid_out) begin
            wr_ptr <= (wr_ptr == page_last) ? '0 : wr_ptr + 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (rx_valid_out && !read_op_in && !(busy_out && buf_sel_in == prog_buf)) begin
            mem[buf_sel_in][wr_ptr] <= rx_data_out;
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prog_data_out <= '0;
        end else if (prog_addr_in <= page_last) begin
            prog_data_out <= mem[prog_buf][prog_addr_in];
        end else begin
            prog_data_out <= '0;
        end
    end

    sff_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_valid_in(tx_valid_in),
        .in_ready_out(tx_ready_out),
        .in_data_in(tx_data_in),
        .out_valid_out(tx_valid),
        .out_ready_in(tx_pop),
        .out_data_out(tx_byte)
    );

    // output shifter; an empty fifo sends zeros
    assign load_out = sck_fall && state == SFF_DATA && read_op_in && bit_cnt == 3'd0;
    assign tx_pop = load_out;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            so_out <= 1'b0;
            out_sh <= '0;
        end else if (sck_fall && state == SFF_DATA && read_op_in) begin
            if (bit_cnt == 3'd0) begin
                so_out <= tx_valid ? tx_byte[7] : 1'b0;
                out_sh <= tx_valid ? {tx_byte[6:0], 1'b0} : 8'h00;
            end else begin
                so_out <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_deselect_standby;
        link_s2.cs_n && !busy_out |-> standby_out && !selected_out;
    endproperty
    a_deselect_standby: assert property (p_deselect_standby) else $error("not in standby");
    property p_so_hiz;
        link_s2.cs_n || abort |-> !so_oe_out;
    endproperty
    a_so_hiz: assert property (p_so_hiz) else $error("output driven while deselected");
    property p_ignore_si;
        link_s2.cs_n |=> !rx_valid_out && !cmd_valid_out;
    endproperty
    a_ignore_si: assert property (p_ignore_si) else $error("input taken while deselected");
    property p_cs_rise_ends;
        cs_rise |=> state == SFF_IDLE;
    endproperty
    a_cs_rise_ends: assert property (p_cs_rise_ends) else $error("frame not ended");
    property p_timed_active;
        cs_rise && state == SFF_DATA && timed_op_in && !busy_out && !abort
            |=> (busy_out && !standby_out) [*8];
    endproperty
    a_timed_active: assert property (p_timed_active) else $error("standby during cycle");
    property p_capture_rise;
        sck_rise && state == SFF_DATA && bit_cnt == 3'd7
            |=> rx_valid_out && rx_data_out[0] == $past(link_s2.si);
    endproperty
    a_capture_rise: assert property (p_capture_rise) else $error("bit not captured");
    property p_so_on_fall;
        $changed(so_out) |-> $past(sck_fall);
    endproperty
    a_so_on_fall: assert property (p_so_on_fall) else $error("output moved off falling edge");
    property p_cycle_len;
        $rose(busy_out) |-> busy_cnt == CNT_W'(CYCLE_CLKS - 1);
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong");
    property p_reset_pin;
        abort |=> state == SFF_IDLE && !busy_out;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");
    property p_restart;
        cs_fall |=> state == SFF_OPCODE && bit_cnt == 3'd0 && addr_cnt == 2'd0;
    endproperty
    a_restart: assert property (p_restart) else $error("decoder not restarted");
    c_command: cover property (cmd_valid_out);
    c_data_byte: cover property (rx_valid_out && busy_out);
    c_cycle_done: cover property ($fell(busy_out));
    c_read_byte: cover property (load_out && tx_valid);
endmodule : sff_front_end

// file: verif/sff_host_model.sv
// Purpose: host side of the serial flash link
// Assumes: sck period 160 ns, unrelated in phase to clk_in
// Notes: sck stands still between frames except in noise, si inverted when released
`timescale 1ns/1ps
module sff_host_model (
    output sff_pkg::sff_link_t link_out,
    input wire logic so_in
);
    import sff_pkg::*;
    initial begin
        link_out = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
    end
    // mode 3 idles sck high; sampling is on the rise in both modes
    task automatic send(input logic m3, input int nbits, input logic [63:0] v,
                        output logic [63:0] got);
        got = '0;
        link_out.sck = m3;
        #80 link_out.cs_n = 1'b0;
        #80;
        for (int i = 0; i < nbits; i++) begin
            link_out.sck = 1'b0;
            link_out.si = v[63-i];
            #80 link_out.sck = 1'b1;
            // late sample leaves room for the input synchroniser and the output register
            #70 got = {got[62:0], so_in};
            #10;
        end
        link_out.sck = m3;
        #80 link_out.cs_n = 1'b1;
        link_out.si = ~link_out.si;
        #160;
    endtask : send
    task automatic noise(input int n);
        for (int i = 0; i < n; i++) begin
            #80 link_out.sck = ~link_out.sck;
            link_out.si = ~link_out.si ^ i[1];
        end
        link_out.sck = 1'b0;
    endtask : noise
endmodule : sff_host_model

// file: verif/serial_flash_spi_front_end_tb_top.sv
// Purpose: self-checking bench of the serial flash front end
// Assumes: CYCLE_CLKS shortened so a second frame fits in one cycle
// Notes: random traffic from seed 1 plus fixed corner frames
`timescale 1ns/1ps
module serial_flash_spi_front_end_tb_top;
    import sff_pkg::*;
    localparam int CYC = 500;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    sff_link_t link;
    logic rpin_n = 1'b1;
    logic page_bin = 1'b0;
    logic buf_sel = 1'b0;
    logic rd_op = 1'b0;
    logic tm_op = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic [8:0] prog_addr = 9'h000;
    logic so, so_oe, tx_ready, cmd_valid, rx_valid, busy, sel, stby;
    sff_cmd_t cmd;
    logic [10:0] page_addr;
    logic [7:0] rx_data, prog_data;
    int mismatches = 0;
    int total_checks = 0;
    int n_cmd = 0;
    int busy_len = 0;
    int busy_cnt = 0;
    logic [31:0] last_cmd;
    logic [7:0] rx_q[$];
    logic [63:0] got;
    logic so_line;
    // a released output shows the inverse of its last level
    assign so_line = so_oe ? so : ~so;

    always #10 clk_in = ~clk_in;

    sff_front_end #(.CYCLE_CLKS(CYC), .FIFO_DEPTH(4)) i_sff_front_end (
        .clk_in(clk_in), .rst_in(rst_in), .link_in(link), .reset_pin_n_in(rpin_n),
        .so_out(so), .so_oe_out(so_oe), .page_bin_in(page_bin), .buf_sel_in(buf_sel),
        .read_op_in(rd_op), .timed_op_in(tm_op), .cmd_out(cmd), .cmd_valid_out(cmd_valid),
        .page_addr_out(page_addr), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
        .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
        .prog_addr_in(prog_addr), .prog_data_out(prog_data), .busy_out(busy),
        .selected_out(sel), .standby_out(stby));

    sff_host_model i_sff_host_model (.link_out(link), .so_in(so_line));

    always @(posedge clk_in) begin
        if (cmd_valid === 1'b1) begin
            last_cmd = cmd;
            n_cmd++;
        end
        if (rx_valid === 1'b1) rx_q.push_back(rx_data);
        if (busy === 1'b1) busy_cnt++;
        else if (busy_cnt != 0) begin
            busy_len = busy_cnt;
            busy_cnt = 0;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask : tick

    function automatic logic [10:0] exp_page(input logic bin, input logic [23:0] a);
        return bin ? a[18:8] : a[19:9];
    endfunction : exp_page

    // write frame: command word then nb data bytes, d right aligned
    task automatic wframe(input logic m3, input logic [31:0] ca, input int nb,
                          input logic [31:0] d);
        logic [63:0] v;
        v = {ca, 32'h0} | (({32'h0, d} << (32 - 8 * nb)) & 64'h0000_0000_FFFF_FFFF);
        rx_q.delete();
        i_sff_host_model.send(m3, 32 + 8 * nb, v, got);
        check("cmd", last_cmd, ca);
        check("page", page_addr, exp_page(page_bin, ca[23:0]));
        check("nbytes", rx_q.size(), nb);
        for (int i = 0; i < nb; i++) check("rx", rx_q[i], d[8*(nb-1-i) +: 8]);
        check("oe_idle", so_oe, 1'b0);
    endtask : wframe

    initial begin
        #1_000_000;
        mismatches++;
        stop_test();
    end

    initial begin
        int k;
        int n0;
        logic [31:0] exp_rd;
        void'($urandom(1));
        repeat (12) @(posedge clk_in);
        #2 rst_in = 1'b0;
        tick(4);
        check("stby_rst", stby, 1'b1);
        i_sff_host_model.noise(40);
        tick(6);
        check("noise_cmd", n_cmd, 0);
        check("noise_oe", so_oe, 1'b0);
        check("noise_sel", sel, 1'b0);
        $display("test deselect done");
        wframe(1'b0, 32'h0000_0000, 1, 32'h5A);
        wframe(1'b1, 32'hFFFF_FFFF, 4, 32'hA5C3_0FF0);
        repeat (6) begin
            tick(1);
            page_bin = 1'($urandom);
            wframe(1'($urandom), 32'($urandom), $urandom_range(1, 4), 32'($urandom));
        end
        $display("test writes done");
        i_sff_host_model.send(1'b0, 13, 64'hFFFF_0000_0000_0000, got);
        wframe(1'b1, 32'h520A_1337, 2, 32'hBEEF);
        $display("test partial done");
        tick(1);
        page_bin = 1'b0;
        tm_op = 1'b1;
        wframe(1'b0, 32'h8200_0105, 1, 32'hC7);
        tick(1);
        tm_op = 1'b0;
        buf_sel = 1'b1;
        prog_addr = 9'h105;
        check("busy", busy, 1'b1);
        check("stby_busy", stby, 1'b0);
        tick(2);
        check("prog", prog_data, 8'hC7);
        wframe(1'b0, 32'h8400_0010, 2, 32'h1234);
        check("busy_on", busy, 1'b1);
        for (k = 0; k < 1000 && busy !== 1'b0; k++) tick(1);
        if (k == 1000) begin
            mismatches++;
            stop_test();
        end
        tick(2);
        check("busy_len", busy_len, CYC);
        check("stby_end", stby, 1'b1);
        tm_op = 1'b1;
        wframe(1'b0, 32'h8300_0020, 1, 32'h77);
        tm_op = 1'b0;
        prog_addr = 9'h010;
        tick(2);
        check("prog_b1", prog_data, 8'h12);
        wframe(1'b0, 32'h8400_0010, 1, 32'h55);
        tick(1);
        check("prog_drop", prog_data, 8'h12);
        for (k = 0; k < 1000 && busy !== 1'b0; k++) tick(1);
        if (k == 1000) begin
            mismatches++;
            stop_test();
        end
        tick(2);
        check("busy_len2", busy_len, CYC);
        $display("test timed done");
        rd_op = 1'b1;
        tx_valid = 1'b1;
        exp_rd = '0;
        for (k = 0; k < 8 && tx_ready === 1'b1; k++) begin
            tx_data = 8'($urandom);
            exp_rd = {exp_rd[23:0], tx_data};
            tick(1);
        end
        tx_valid = 1'b0;
        check("fill", k, 4);
        i_sff_host_model.send(1'b0, 64, 64'h0B00_0000_0000_0000, got);
        check("rd", got[31:0], exp_rd);
        check("drained", tx_ready, 1'b1);
        rd_op = 1'b0;
        $display("test read done");
        n0 = n_cmd;
        fork
            i_sff_host_model.send(1'b0, 40, 64'h82AB_CDEF_1100_0000, got);
            begin
                #1500 tick(1);
                rpin_n = 1'b0;
                tick(10);
                check("rpin_oe", so_oe, 1'b0);
                check("rpin_sel", sel, 1'b0);
                tick(15);
                rpin_n = 1'b1;
            end
        join
        check("rpin_cmd", n_cmd, n0);
        wframe(1'b0, 32'h8866_4422, 1, 32'h99);
        $display("test reset pin done");
        stop_test();
    end
endmodule : serial_flash_spi_front_end_tb_top
